/* pdts_pkg.sv */
/*
  Shared types and constants of the source-side power transition sequencer.
  Assumes one 40 MHz clock.
*/
`default_nettype none

package pdts_pkg;

  // ==========================================================================
  // timing
  localparam int unsigned CLK_PERIOD_NS = 25;
  // plain defaults: the interval figures are not fixed here
  localparam int unsigned SNK_TRANS_NS = 25000000;
  localparam int unsigned SRC_READY_NS = 285000000;
  // least wait rounds up, longest bound rounds down
  localparam int unsigned SNK_TRANS_CYC = (SNK_TRANS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SRC_READY_CYC = SRC_READY_NS / CLK_PERIOD_NS;
  localparam int unsigned CNT_W = 24;
  localparam int unsigned SYNC_STAGES = 2;

  // ==========================================================================
  // message kinds sent to the sink
  typedef enum logic
  {
    PDTS_MSG_ACCEPT = 1'b0,
    PDTS_MSG_PS_RDY = 1'b1
  } pdts_msgk_t;

  typedef struct packed
  {
    logic valid;
    pdts_msgk_t kind;
  } pdts_msg_t;

  // answer of the protocol layer to the last message
  typedef struct packed
  {
    logic goodcrc;
    logic fail;
  } pdts_ack_t;

  // ==========================================================================
  // sequencer states, gray from PDTS_IDLE through PDTS_RDY_ACK
  typedef enum logic [2:0]
  {
    PDTS_IDLE = 3'h0,
    PDTS_ACC_ACK = 3'h1,
    PDTS_SNK_WAIT = 3'h3,
    PDTS_SUP_WAIT = 3'h2,
    PDTS_RDY_ACK = 3'h6
  } pdts_state_t;

endpackage

`default_nettype wire

/* pdts_timer.sv */
/*
  One-shot down counter used for the sink transition wait and the supply
  readiness bound. Assumes start and load come from the same clock domain.
*/
`default_nettype none

module pdts_timer #(
  parameter int unsigned W = pdts_pkg::CNT_W
) (
  input wire logic clk, // system clock
  input wire logic resetn, // synchronous reset, active low
  input wire logic start, // pulse: load and run
  input wire logic [W-1:0] load, // cycles minus one
  output logic expired // high in the cycle the count runs out
);

  // ==========================================================================
  // counter
  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;
  logic run_q;
  logic run_d;

  assign expired = run_q && (cnt_q == '0);

  always_comb
  begin
    cnt_d = cnt_q;
    run_d = run_q;
    // a restart overrides a running count
    if (start)
    begin
      cnt_d = load;
      run_d = 1'b1;
    end
    else if (run_q)
    begin
      if (cnt_q == '0)
      begin
        run_d = 1'b0;
      end
      else
      begin
        cnt_d = cnt_q - W'(1);
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      cnt_q <= '0;
      run_q <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_d;
      run_q <= run_d;
    end
  end

endmodule

`default_nettype wire

/* pdts_source_seq.sv */
/*
  Source-side sequencer for a negotiated supply change: accept, wait for the
  sink, command the supply, report readiness to the sink.
  Assumes the protocol layer and policy logic share clk; supply ready is a pin.
*/
`default_nettype none

// Overview of operation
// R01: after the sink wait, command the supply to the new level.
// R02: supply must be ready within the readiness bound after the command.
// R03: supply readiness is reported and forwarded to the sequencer.
// R04: on readiness send PS_RDY, then await its acknowledgement.
// R05: sink returns GoodCRC for PS_RDY before acting on it.
// R06: sink evaluates PS_RDY and permits drawing new power.
// R07: sink may draw new power any time after evaluating PS_RDY.
// R08: a transition starts by sending Accept for the pending request.
// R09: sink starts its transition timer on receiving Accept.
// R10: sink acknowledges Accept with GoodCRC, then evaluates it.
// R11: after GoodCRC for Accept, wait the sink interval before commanding.
// R12: the sink wait begins only once GoodCRC for Accept arrives.
// R13: sink drops to standby power before the sink wait ends.
// R14: sink abandons on timer expiry before PS_RDY is evaluated.

module pdts_source_seq #(
  parameter int unsigned SNK_TRANS_CYC = pdts_pkg::SNK_TRANS_CYC,
  parameter int unsigned SRC_READY_CYC = pdts_pkg::SRC_READY_CYC
) (
  input wire logic clk, // 40 MHz system clock
  input wire logic resetn, // synchronous reset, active low
  input wire logic start, // pulse: pending request to be accepted
  input wire pdts_pkg::pdts_ack_t ack, // protocol layer answer, pulses
  input wire logic ps_ready, // supply ready pin, asynchronous
  output var pdts_pkg::pdts_msg_t msg_tx, // message to send, valid pulse
  output logic ps_cmd, // pulse: supply, move to new level
  output logic busy, // transition under way
  output logic done, // pulse: PS_RDY acknowledged
  output logic err // pulse: sequence abandoned
);

  // ==========================================================================
  // supply ready synchroniser
  logic [pdts_pkg::SYNC_STAGES-1:0] sync_q;
  logic [pdts_pkg::SYNC_STAGES-1:0] sync_d;
  logic rdy_s;

  always_comb
  begin
    sync_d = {sync_q[pdts_pkg::SYNC_STAGES-2:0], ps_ready};
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      sync_q <= '0;
    end
    else
    begin
      sync_q <= sync_d;
    end
  end

  // R03 forwarded readiness
  assign rdy_s = sync_q[pdts_pkg::SYNC_STAGES-1];

  // ==========================================================================
  // shared interval timer
  logic tmr_start;
  logic [pdts_pkg::CNT_W-1:0] tmr_load;
  logic tmr_done;

  pdts_timer #(
    .W(pdts_pkg::CNT_W)
  ) u_timer (
    .clk(clk),
    .resetn(resetn),
    .start(tmr_start),
    .load(tmr_load),
    .expired(tmr_done)
  );

  // ==========================================================================
  // sequencer
  pdts_pkg::pdts_state_t state_q;
  pdts_pkg::pdts_state_t state_d;
  pdts_pkg::pdts_msg_t msg_q;
  pdts_pkg::pdts_msg_t msg_d;
  logic ps_cmd_q;
  logic ps_cmd_d;
  logic busy_q;
  logic busy_d;
  logic done_q;
  logic done_d;
  logic err_q;
  logic err_d;

  always_comb
  begin
    state_d = state_q;
    msg_d = '0;
    ps_cmd_d = 1'b0;
    done_d = 1'b0;
    err_d = 1'b0;
    tmr_start = 1'b0;
    tmr_load = '0;
    case (state_q)
      pdts_pkg::PDTS_IDLE:
      begin
        // R08 accept opens the transition
        if (start)
        begin
          msg_d.valid = 1'b1;
          msg_d.kind = pdts_pkg::PDTS_MSG_ACCEPT;
          state_d = pdts_pkg::PDTS_ACC_ACK;
        end
      end
      pdts_pkg::PDTS_ACC_ACK:
      begin
        // R12 wait starts on goodcrc
        if (ack.goodcrc)
        begin
          tmr_start = 1'b1;
          tmr_load = pdts_pkg::CNT_W'(SNK_TRANS_CYC - 1);
          state_d = pdts_pkg::PDTS_SNK_WAIT;
        end
        else if (ack.fail)
        begin
          err_d = 1'b1;
          state_d = pdts_pkg::PDTS_IDLE;
        end
      end
      pdts_pkg::PDTS_SNK_WAIT:
      begin
        // R11 R01 command after wait
        if (tmr_done)
        begin
          ps_cmd_d = 1'b1;
          tmr_start = 1'b1;
          tmr_load = pdts_pkg::CNT_W'(SRC_READY_CYC - 1);
          state_d = pdts_pkg::PDTS_SUP_WAIT;
        end
      end
      pdts_pkg::PDTS_SUP_WAIT:
      begin
        // R04 ready wins over a same-cycle timeout
        if (rdy_s)
        begin
          msg_d.valid = 1'b1;
          msg_d.kind = pdts_pkg::PDTS_MSG_PS_RDY;
          state_d = pdts_pkg::PDTS_RDY_ACK;
        end
        // R02 readiness bound broken
        else if (tmr_done)
        begin
          err_d = 1'b1;
          state_d = pdts_pkg::PDTS_IDLE;
        end
      end
      pdts_pkg::PDTS_RDY_ACK:
      begin
        // R04 await the acknowledgement
        if (ack.goodcrc)
        begin
          done_d = 1'b1;
          state_d = pdts_pkg::PDTS_IDLE;
        end
        else if (ack.fail)
        begin
          err_d = 1'b1;
          state_d = pdts_pkg::PDTS_IDLE;
        end
      end
      default:
      begin
        state_d = pdts_pkg::PDTS_IDLE;
      end
    endcase
    busy_d = (state_d != pdts_pkg::PDTS_IDLE);
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      state_q <= pdts_pkg::PDTS_IDLE;
      msg_q <= '0;
      ps_cmd_q <= 1'b0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
      err_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      msg_q <= msg_d;
      ps_cmd_q <= ps_cmd_d;
      busy_q <= busy_d;
      done_q <= done_d;
      err_q <= err_d;
    end
  end

  assign msg_tx = msg_q;
  assign ps_cmd = ps_cmd_q;
  assign busy = busy_q;
  assign done = done_q;
  assign err = err_q;

  // ==========================================================================
  // checks
  AST_ACCEPT_FIRST: assert property ( // R08
    @(posedge clk) disable iff (!resetn)
    (state_q == pdts_pkg::PDTS_IDLE && start)
      |=> (msg_q.valid && msg_q.kind == pdts_pkg::PDTS_MSG_ACCEPT && busy_q))
    else $error("accept not sent on start");

  AST_WAIT_ON_CRC: assert property ( // R12
    @(posedge clk) disable iff (!resetn)
    (state_q == pdts_pkg::PDTS_ACC_ACK && ack.goodcrc)
      |=> (state_q == pdts_pkg::PDTS_SNK_WAIT) ##1 !ps_cmd_q)
    else $error("sink wait not begun on goodcrc");

  AST_NO_EARLY_CMD: assert property ( // R11
    @(posedge clk) disable iff (!resetn)
    ps_cmd_q |-> ($past(state_q) == pdts_pkg::PDTS_SNK_WAIT && $past(tmr_done)))
    else $error("supply commanded before sink wait ended");

  AST_CMD_ON_EXPIRY: assert property ( // R01
    @(posedge clk) disable iff (!resetn)
    (state_q == pdts_pkg::PDTS_SNK_WAIT && tmr_done)
      |=> (ps_cmd_q && state_q == pdts_pkg::PDTS_SUP_WAIT) ##1 !ps_cmd_q)
    else $error("supply not commanded after sink wait");

  AST_READY_BOUND: assert property ( // R02
    @(posedge clk) disable iff (!resetn)
    (state_q == pdts_pkg::PDTS_SUP_WAIT && tmr_done && !rdy_s)
      |=> (err_q && !busy_q && !msg_q.valid))
    else $error("late supply not flagged");

  AST_READY_FWD: assert property ( // R03
    @(posedge clk) disable iff (!resetn)
    (state_q == pdts_pkg::PDTS_SUP_WAIT && $rose(rdy_s))
      |=> (msg_q.valid && msg_q.kind == pdts_pkg::PDTS_MSG_PS_RDY))
    else $error("readiness not forwarded");

  AST_PSRDY_CAUSE: assert property ( // R04
    @(posedge clk) disable iff (!resetn)
    (msg_q.valid && msg_q.kind == pdts_pkg::PDTS_MSG_PS_RDY)
      |-> ($past(rdy_s) && state_q == pdts_pkg::PDTS_RDY_ACK))
    else $error("ps_rdy sent without readiness");

  AST_PSRDY_ACKED: assert property ( // R04
    @(posedge clk) disable iff (!resetn)
    done_q |-> ($past(state_q) == pdts_pkg::PDTS_RDY_ACK && $past(ack.goodcrc) && !busy_q))
    else $error("done without ps_rdy acknowledgement");

endmodule

`default_nettype wire

/* pdts_peer.sv */
/*
  Behavioural sink-side peer: acknowledges messages, runs its transition
  timer and permits the new level. Assumes the source shares clk.
*/
`default_nettype none

module pdts_peer #(
  parameter int TMR = 200
) (
  input wire logic clk, // system clock
  input wire logic resetn, // synchronous reset, active low
  input wire pdts_pkg::pdts_msg_t msg_tx, // message from the source
  input var int dly, // cycles until the answer
  input wire logic [1:0] nak, // refuse: bit 0 accept, bit 1 ps_rdy
  output var pdts_pkg::pdts_ack_t ack, // answer pulses
  output var logic permit // pulse: new level may be drawn
);
  timeunit 1ns;
  timeprecision 100ps;
  int cnt = 0;
  int tmr = 0;
  logic v;
  logic k;
  logic r;
  logic fl;
  logic kind_q = 1'b0;
  pdts_pkg::pdts_ack_t ack_n;
  logic permit_n;

  initial ack = '0;
  initial permit = 1'b0;
  // ==========================================================================
  // answers
  always @(posedge clk)
  begin
    // reset sampled on the edge: the bench moves it 1 ns later
    v = msg_tx.valid;
    k = msg_tx.kind;
    r = resetn;
    #1;
    ack_n = '0;
    permit_n = 1'b0;
    if (!r)
    begin
      cnt = 0;
      tmr = 0;
    end
    else
    begin
      if (cnt == 1)
      begin
        fl = nak[kind_q];
        ack_n.goodcrc = !fl;
        ack_n.fail = fl;
        permit_n = !fl && kind_q === 1'b1;
        if (permit_n)
          tmr = 0;
      end
      if (cnt > 0)
        cnt--;
      if (v)
      begin
        cnt = dly;
        kind_q = k;
        if (!k)
          tmr = TMR;
      end
      if (tmr == 1)
        cnt = 0;
      if (tmr > 0)
        tmr--;
    end
    ack = ack_n;
    permit = permit_n;
  end
endmodule

`default_nettype wire

/* tb_pdts_source_seq.sv */
/*
  Self-checking bench of the source sequencer with a sink peer and a supply.
  Assumes shortened timer parameters; inputs move 1 ns after each edge.
*/
`default_nettype none

module tb_pdts_source_seq;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int N = 8;
  localparam int S = 20;
  typedef struct {int adly; int rdly; bit [1:0] nak; bit dbl; bit ok;} pdts_tb_row_t;
  // boundary pair: ready just in time, then one cycle late; then each ack refused
  pdts_tb_row_t rows[6] = '{'{1, 0, 2'h0, 0, 1}, '{3, 2, 2'h0, 1, 1}, '{1, S-4, 2'h0, 0, 1},
    '{1, S-3, 2'h0, 0, 0}, '{2, 0, 2'h1, 0, 0}, '{1, 0, 2'h2, 0, 0}};
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic start = 1'b0;
  logic ps_ready = 1'b0;
  logic [1:0] nak = 2'h0;
  logic permit;
  int dly = 1;
  pdts_pkg::pdts_ack_t ack;
  pdts_pkg::pdts_msg_t msg_tx;
  logic ps_cmd;
  logic busy;
  logic done;
  logic err;
  int fails = 0;
  int check_count = 0;
  int cyc = 0;
  int rd = 0;
  int rcnt = 0;
  int n_acc, n_perm, n_busy, t_st, t_acc, t_cmd, t_rdy, t_ps, t_f, t_end;
  int t_g[2];
  logic kind_l = 1'b0;
  logic got_done;

  always #12.5 clk = ~clk;

  pdts_source_seq #(.SNK_TRANS_CYC(N), .SRC_READY_CYC(S)) dut_u (.clk(clk),
    .resetn(resetn), .start(start), .ack(ack), .ps_ready(ps_ready), .msg_tx(msg_tx),
    .ps_cmd(ps_cmd), .busy(busy), .done(done), .err(err));
  pdts_peer peer_u (.clk(clk), .resetn(resetn), .msg_tx(msg_tx), .dly(dly), .nak(nak),
    .ack(ack), .permit(permit));

  // ==========================================================================
  // monitor and supply model
  always @(posedge clk)
  begin
    cyc++;
    if (start && t_st < 0)
      t_st = cyc;
    if (msg_tx.valid)
    begin
      kind_l = msg_tx.kind;
      if (kind_l)
        t_ps = cyc;
      else
      begin
        n_acc++;
        t_acc = cyc;
      end
    end
    if (ack.goodcrc)
      t_g[kind_l] = cyc;
    if (ack.fail)
      t_f = cyc;
    if (ps_cmd)
    begin
      t_cmd = cyc;
      rcnt = rd + 1;
    end
    if (ps_ready && t_rdy < 0)
      t_rdy = cyc;
    if (done || err)
    begin
      t_end = cyc;
      got_done = done;
    end
    if (permit)
      n_perm++;
    if (busy)
      n_busy++;
    #1;
    if (rcnt > 0)
    begin
      rcnt--;
      if (rcnt == 0)
        ps_ready = 1'b1;
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      fails++;
      $display("ERROR %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task results();
    if (fails == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic run(input pdts_tb_row_t r);
    n_acc = 0;
    n_perm = 0;
    n_busy = 0;
    {t_st, t_acc, t_cmd, t_rdy, t_ps, t_f, t_end} = {7{32'hffffffff}};
    t_g = '{-1, -1};
    ps_ready = 1'b0;
    dly = r.adly;
    nak = r.nak;
    rd = r.rdly;
    @(posedge clk);
    #1 start = 1'b1;
    @(posedge clk);
    #1 start = r.dbl;
    @(posedge clk);
    #1 start = 1'b0;
    // polled 1 ns after each edge, clear of the monitor's own edge
    for (int i = 0; i < 200 && t_end < 0; i++)
      #25;
    check(t_acc - t_st, 1);
    check(n_acc, 1);
    check(n_busy, t_end - t_st - 1);
    if (r.nak[0])
      check(t_end - t_f, 1);
    else
      check(t_cmd - t_g[0], N + 1);
    if (r.ok || r.nak[1])
    begin
      check(t_ps - t_rdy, 3);
      check(t_end - (r.ok ? t_g[1] : t_f), 1);
      check(n_perm, r.ok);
    end
    else if (!r.nak[0])
    begin
      check(t_end - t_cmd, S);
      check(t_ps, -1);
    end
    check(got_done, r.ok);
  endtask

  initial
  begin
    repeat (4) @(posedge clk);
    #1 check(32'({msg_tx, ps_cmd, busy, done, err}), 32'h0);
    resetn = 1'b1;
    foreach (rows[i])
      run(rows[i]);
    // reset in mid-sequence must drop everything
    ps_ready = 1'b0;
    start = 1'b1;
    @(posedge clk);
    #1 start = 1'b0;
    repeat (3) @(posedge clk);
    #1 resetn = 1'b0;
    @(posedge clk);
    #1 check(32'({msg_tx, ps_cmd, busy, done, err}), 32'h0);
    resetn = 1'b1;
    run(rows[0]);
    results();
  end

  initial
  begin
    repeat (5000) @(posedge clk);
    fails++;
    results();
  end
endmodule

`default_nettype wire
